// ===== design/tc_status_pkg.sv
// Package: register map, field layout and bus types of the channel status block
package tc_status_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] channel_status_off         = 8'h20;
   localparam logic [7:0] interrupt_enable_set_off   = 8'h24;
   localparam logic [7:0] interrupt_enable_clear_off = 8'h28;
   localparam logic [7:0] interrupt_enable_mask_off  = 8'h2c;
   localparam logic [7:0] compare_value_c_off        = 8'h1c;
   localparam int         addr_bits                  = 8;

   // ****************************************
   // Status field positions
   // ****************************************
   localparam int overflow_bit       = 0;
   localparam int load_overrun_bit   = 1;
   localparam int compare_a_bit      = 2;
   localparam int compare_b_bit      = 3;
   localparam int compare_c_bit      = 4;
   localparam int load_a_bit         = 5;
   localparam int load_b_bit         = 6;
   localparam int ext_trigger_bit    = 7;
   localparam int event_count        = 8;
   localparam int clock_running_bit  = 16;
   localparam int line_a_mirror_bit  = 17;
   localparam int line_b_mirror_bit  = 18;
   localparam int value_width        = 16;

   localparam logic [event_count-1:0] mask_reset = 8'h00;
   localparam logic [31:0]            word_zero  = 32'h0000_0000;

   // ****************************************
   // AHB-Lite codes
   // ****************************************
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [1:0] htrans_seq    = 2'h3;

   // Event strobes from the channel datapath, one cycle each
   typedef struct packed {
      logic ext_trigger;
      logic load_b;
      logic load_a;
      logic compare_c;
      logic compare_b;
      logic compare_a;
      logic load_overrun;
      logic overflow;
   } events_t;

   // Latched data phase of one bus transfer
   typedef struct packed {
      logic                 valid;
      logic                 write;
      logic [addr_bits-1:0] addr;
   } bus_phase_t;

endpackage : tc_status_pkg

// ===== design/timer_channel_status_irq.sv
// Status flags, interrupt mask and AHB-Lite slave of one timer channel
`timescale 1ns/100ps

module timer_channel_status_irq
   import tc_status_pkg::*;
(
   // Clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // Channel datapath
   input  wire logic                   output_generation_mode,
   input  wire logic                   clock_enabled,
   input  wire events_t                event_strobe,
   input  wire logic                   value_a_read,
   input  wire logic                   value_b_read,
   input  wire logic [value_width-1:0] compare_value_c,
   input  wire logic                   line_a_drive,
   input  wire logic                   line_b_drive,
   // Channel pins
   input  wire logic                   io_line_a,
   input  wire logic                   io_line_b,
   // Interrupt
   output logic                        irq
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] line_a_sync;
   logic [1:0] line_b_sync;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_a_sync <= 2'h0;
         line_b_sync <= 2'h0;
      end else begin
         line_a_sync <= {line_a_sync[0], io_line_a};
         line_b_sync <= {line_b_sync[0], io_line_b};
      end
   end

   // ****************************************
   // Bus address phase capture
   // ****************************************
   bus_phase_t phase;
   logic       take;

   assign take = hsel && hready && (htrans == htrans_nonseq || htrans == htrans_seq);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= '0;
      end else if (hready) begin
         phase.valid <= take;
         phase.write <= hwrite;
         phase.addr  <= haddr[addr_bits-1:0];
      end
   end

   // Whole-word writes only act; narrower writes are answered but ignored, reads of any size act
   logic       size_ok;
   logic       size_ok_q;

   assign size_ok = (hsize == 3'h2);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         size_ok_q <= 1'b0;
      end else if (hready) begin
         size_ok_q <= size_ok;
      end
   end

   function automatic logic hit(input bus_phase_t p, input logic wr, input logic [7:0] off);
      hit = p.valid && (p.write == wr) && (p.addr == off);
   endfunction : hit

   logic status_read;
   logic set_write;
   logic clear_write;

   assign status_read = hit(phase, 1'b0, channel_status_off);
   assign set_write   = size_ok_q && hit(phase, 1'b1, interrupt_enable_set_off);
   assign clear_write = size_ok_q && hit(phase, 1'b1, interrupt_enable_clear_off);

   // ****************************************
   // Event qualification by mode
   // ****************************************
   logic                   waveform;
   logic [event_count-1:0] event_in;
   logic                   a_loaded;
   logic                   b_loaded;
   logic                   overrun;

   assign waveform = output_generation_mode;

   // Unread-load trackers for capture mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_loaded <= 1'b0;
         b_loaded <= 1'b0;
      end else begin
         a_loaded <= !waveform && (event_strobe.load_a || (a_loaded && !value_a_read));
         b_loaded <= !waveform && (event_strobe.load_b || (b_loaded && !value_b_read));
      end
   end

   assign overrun = !waveform
                    && ((event_strobe.load_a && a_loaded && !value_a_read)
                        || (event_strobe.load_b && b_loaded && !value_b_read));

   always_comb begin
      event_in                    = '0;
      event_in[overflow_bit]      = event_strobe.overflow;
      event_in[load_overrun_bit]  = overrun;
      event_in[compare_a_bit]     = waveform && event_strobe.compare_a;
      event_in[compare_b_bit]     = waveform && event_strobe.compare_b;
      event_in[compare_c_bit]     = event_strobe.compare_c;
      event_in[load_a_bit]        = !waveform && event_strobe.load_a;
      event_in[load_b_bit]        = !waveform && event_strobe.load_b;
      event_in[ext_trigger_bit]   = event_strobe.ext_trigger;
   end

   // ****************************************
   // Sticky flags and mask
   // ****************************************
   logic [event_count-1:0] flags;
   logic [event_count-1:0] mask;
   logic [event_count-1:0] next_flags;
   logic [event_count-1:0] next_mask;

   genvar gi;
   generate
      for (gi = 0; gi < event_count; gi++) begin : g_bit
         // Set wins over the read-clear
         assign next_flags[gi] = event_in[gi] || (flags[gi] && !status_read);
         assign next_mask[gi]  = (set_write && hwdata[gi])
                                 || (mask[gi] && !(clear_write && hwdata[gi]));
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask <= mask_reset;
      end else begin
         mask <= next_mask;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_flags & next_mask);
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   logic [31:0] status_word;
   logic [31:0] next_rdata;

   always_comb begin
      status_word                    = word_zero;
      // Events of the address phase cycle join the read, else the clear drops them
      status_word[event_count-1:0]   = flags | event_in;
      status_word[clock_running_bit] = clock_enabled;
      status_word[line_a_mirror_bit] = waveform ? line_a_drive : line_a_sync[1];
      status_word[line_b_mirror_bit] = waveform ? line_b_drive : line_b_sync[1];
   end

   // Decode on the incoming address phase so data stand in the data phase
   always_comb begin
      next_rdata = word_zero;
      if (!(take && !hwrite)) begin
         next_rdata = word_zero;
      end else if (haddr[addr_bits-1:0] == channel_status_off) begin
         next_rdata = status_word;
      end else if (haddr[addr_bits-1:0] == interrupt_enable_mask_off) begin
         next_rdata[event_count-1:0] = mask;
      end else if (haddr[addr_bits-1:0] == compare_value_c_off) begin
         next_rdata[value_width-1:0] = compare_value_c;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= word_zero;
      end else if (hready) begin
         hrdata <= next_rdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

endmodule : timer_channel_status_irq

// ===== testbench/timer_channel_status_irq_assertions.sv
// Checker of bus answers and interrupt timing of the timer channel status block
`timescale 1ns/100ps
module timer_channel_status_irq_checker
   import tc_status_pkg::*;
(
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // AHB-Lite slave
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Channel
   input wire logic        output_generation_mode,
   input wire logic        clock_enabled,
   input wire events_t     event_strobe,
   input wire logic [15:0] compare_value_c,
   input wire logic        line_a_drive,
   input wire logic        line_b_drive,
   input wire logic        irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   function automatic logic acc(logic w, logic [7:0] a);
      return hsel && hready && htrans[1] && hwrite == w && haddr[7:0] == a;
   endfunction : acc

   function automatic logic wr(logic [7:0] a);
      return acc(1'b1, a) && hsize == 3'h2;
   endfunction : wr

   // ****************************************
   // Mask enable, then no disable on the way
   // ****************************************
   sequence en_gap;
      wr(8'h24) ##1 (hwdata[0] && !wr(8'h28)) ##1 !wr(8'h28);
   endsequence

   okay_resp_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   clk_status_a: assert property (acc(1'b0, 8'h20) |=> hrdata[16] == $past(clock_enabled))
      else $error("status clock bit wrong");
   line_a_wave_a: assert property (acc(1'b0, 8'h20) && output_generation_mode |=>
      hrdata[17] == $past(line_a_drive)) else $error("line a mirror wrong");
   line_b_wave_a: assert property (acc(1'b0, 8'h20) && output_generation_mode |=>
      hrdata[18] == $past(line_b_drive)) else $error("line b mirror wrong");
   value_c_read_a: assert property (acc(1'b0, 8'h1c) |=>
      hrdata == {16'h0, $past(compare_value_c)}) else $error("value c read wrong");
   ovf_same_read_a: assert property (acc(1'b0, 8'h20) && event_strobe.overflow |=> hrdata[0])
      else $error("overflow in read cycle lost");
   disable_all_a: assert property (wr(8'h28) ##1 (hwdata[7:0] == 8'hff) |=> !irq)
      else $error("irq after full disable");
   enable_irq_a: assert property (en_gap ##1 event_strobe.overflow |=> irq)
      else $error("enabled overflow gave no irq");
   unmapped_zero_a: assert property (acc(1'b0, 8'h30) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : timer_channel_status_irq_checker

bind timer_channel_status_irq timer_channel_status_irq_checker i_checker (.*);

// ===== testbench/tb_timer_channel_status_irq.sv
// Self-checking bench of the timer channel status block
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_timer_channel_status_irq;
   import tc_status_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, pa, pb;
   logic        output_generation_mode, clock_enabled, value_a_read, value_b_read;
   logic        line_a_drive, line_b_drive, io_line_a, io_line_b;
   logic [31:0] haddr, hwdata, hrdata, rd, w;
   logic [31:0] seed = 32'd33053;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] compare_value_c;
   logic [7:0]  mflags, mmask;
   events_t     event_strobe;
   int          n_fail, tests_run;

   assign hready = hreadyout;
   timer_channel_status_irq i_dut (.*);

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic stop_test();
      if (n_fail == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // ****************************************
   // Single word transfer, bounded waits
   // ****************************************
   task automatic bus(input logic wt, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= htrans_nonseq;
      haddr <= {24'h0, a};
      hwrite <= wt;
      k = 0;
      do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 20);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 20);
      rd = hrdata;
      if (k >= 20) begin
         n_fail++;
         stop_test();
      end
   endtask : bus

   // Bits 9:8 are register reads, 7:0 event pulses
   task automatic ev(input logic [9:0] x);
      @(posedge hclk);
      event_strobe <= x[7:0];
      value_a_read <= x[8];
      value_b_read <= x[9];
      @(posedge hclk);
      event_strobe <= '0;
      value_a_read <= 1'b0;
      value_b_read <= 1'b0;
      if (output_generation_mode) begin
         mflags |= x[7:0] & 8'h9d;
         pa = 0;
         pb = 0;
      end else begin
         mflags[1] |= (x[5] & pa) | (x[6] & pb);
         pa = (pa & !x[8]) | x[5];
         pb = (pb & !x[9]) | x[6];
         mflags |= x[7:0] & 8'hf1;
      end
   endtask : ev

   task automatic rd_status();
      logic [31:0] e;
      @(negedge hclk);
      e = {13'h0, output_generation_mode ? {line_b_drive, line_a_drive} : {io_line_b, io_line_a},
           clock_enabled, 8'h0, mflags};
      `CHK("irq", |(mflags & mmask), irq)
      bus(1'b0, 8'h20, 32'h0);
      `CHK("status", e, rd)
      mflags = 8'h0;
   endtask : rd_status

   initial begin
      {hsel, hwrite, output_generation_mode, clock_enabled, pa, pb} = '0;
      {value_a_read, value_b_read, line_a_drive, line_b_drive, io_line_a, io_line_b} = '0;
      {haddr, hwdata, htrans, compare_value_c, event_strobe, mflags, mmask} = '0;
      {hresetn, n_fail, tests_run} = '0;
      hsize = 3'h2;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 8'h2c, 32'h0);
      `CHK("mask", 32'h0, rd)
      rd_status();
      repeat (4) begin
         w = rnd();
         bus(1'b1, 8'h24, w);
         mmask |= w[7:0];
         w = rnd();
         bus(1'b1, 8'h28, w);
         mmask &= ~w[7:0];
         bus(1'b0, 8'h2c, 32'h0);
         `CHK("mask", {24'h0, mmask}, rd)
      end
      bus(1'b1, 8'h24, 32'h1);
      mmask |= 8'h01;
      ev(10'h001);
      rd_status();
      for (int m = 1; m >= 0; m--) begin
         w = rnd();
         output_generation_mode <= m[0];
         {io_line_b, io_line_a, line_b_drive, line_a_drive, clock_enabled} <= w[4:0];
         ev(10'h0fd);
         rd_status();
         rd_status();
      end
      ev(10'h300);
      ev(10'h040);
      rd_status();
      ev(10'h020);
      ev(10'h020);
      rd_status();
      fork
         bus(1'b0, 8'h20, 32'h0);
         begin
            @(posedge hclk);
            event_strobe <= 8'h01;
            repeat (2) @(posedge hclk);
            event_strobe <= '0;
         end
      join
      `CHK("ovf", 1'b1, rd[0])
      mflags = 8'h01;
      rd_status();
      w = rnd();
      compare_value_c <= w[15:0];
      bus(1'b0, 8'h1c, 32'h0);
      `CHK("value_c", {16'h0, w[15:0]}, rd)
      bus(1'b1, 8'h30, 32'hff);
      bus(1'b0, 8'h30, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      bus(1'b1, 8'h28, 32'hff);
      mmask = 8'h0;
      ev(10'h0fd);
      rd_status();
      stop_test();
   end
endmodule : tb_timer_channel_status_irq
